// File: src/vpw_err_ctrl.sv
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none
module vpw_err_ctrl (
    // Clock and reset
    input wire logic I_CORE_CLK,
    input wire logic I_RST_N,
    // Avalon-MM slave
    input wire logic [vpw_pkg::ADDR_W-1:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    input wire logic [3:0] I_AVS_BYTEENABLE,
    output logic [31:0] O_AVS_READDATA,
    output logic O_AVS_WAITREQUEST,
    // Bus line and decoded symbols
    input wire logic I_BUS_RECEIVE_INPUT,
    input wire vpw_pkg::sym_type I_SYM,
    input wire logic I_PRESCALE_TICK,
    // Transmitter side
    input wire logic I_TRANSMITTING,
    input wire logic I_TX_ABORT,
    input wire logic I_TX_OUTPUT_REQ,
    output logic O_BUS_TRANSMIT_OUTPUT,
    output logic O_CANCEL_QUEUE,
    // Interrupt and DMA sources
    input wire vpw_pkg::src_type I_SRC_REQ,
    input wire logic I_RECEIVE_END_OF_BLOCK_SET,
    input wire logic I_TRANSMIT_END_OF_BLOCK_SET,
    output vpw_pkg::src_type O_GRANT,
    output logic O_RX_FULL,
    output logic O_END_OF_DATA_MINIMUM_EVENT
);
    import vpw_pkg::*;

    // Bus decode; one wait state for every access
    logic ack_r;
    logic [7:0] rdata_r;
    wire [7:0] idx = I_AVS_ADDRESS[ADDR_W-1:2];
    wire req = I_AVS_READ | I_AVS_WRITE;
    wire done = req & ack_r;
    wire wr_done = I_AVS_WRITE & ack_r & I_AVS_BYTEENABLE[0];
    wire rd_done = I_AVS_READ & ack_r;
    wire [7:0] wd = I_AVS_WRITEDATA[7:0];
    wire sel_rx = (idx == IDX_RECEIVE_DATA_REG);
    wire sel_ctl = (idx == IDX_CTRL);
    wire sel_err = (idx == IDX_ERR);
    wire sel_vec = (idx == IDX_VEC);
    wire sel_prio = (idx == IDX_PRIO);
    assign O_AVS_WAITREQUEST = req & ~ack_r;
    assign O_AVS_READDATA = {24'h0000_00, rdata_r};

    // Storage
    logic [7:0] ctl_r;            // Enable, freeze, options
    logic [7:0] err_r;            // Sticky error flags
    logic [4:0] vbase_r;          // Vector base
    logic [2:0] prl_r;            // Priority level
    logic sleep_r;                // Receiver sleep
    logic receive_end_of_block_r;                 // Receive end-of-block pending
    logic transmit_end_of_block_r;                 // Transmit end-of-block pending
    logic [7:0] rxd_r;            // Receive data register
    logic full_r;                 // Receive data unread
    rx_state_type st_r;           // Frame tracker
    rx_state_type st_nxt;
    logic [7:0] crc_r;            // Running CRC
    logic [7:0] shf_r;            // Byte assembly
    logic [2:0] bcnt_r;           // Bits in current byte
    logic [3:0] ycnt_r;           // Bytes in frame, saturating
    logic crc_chk_r;              // Segment carries a CRC
    logic eodm2_r;                // Second END_OF_DATA_MINIMUM seen in frame
    logic brk_r;                  // Break already reported
    logic end_of_data_minimum_seen_r;            // End of data already seen in frame
    logic rxd_d_r;                // Previous bus level
    logic [8:0] run_r;            // Cycles since last edge
    logic [11:0] tmo_r;           // Transmit active ticks

    // Block state
    wire en = ctl_r[CTL_EN];
    wire frz = ctl_r[CTL_FRZ];
    wire kill = ~en | frz;
    wire act = ~kill & ~err_r[ERR_TTO];
    // Frame errors stay quiet while asleep and silent
    wire quiet = sleep_r & ~I_TRANSMITTING;
    wire live = act & (st_r != RX_LOCK);

    // Symbol events, only while the block runs
    wire s_sof = act & I_SYM.sof;
    wire s_nb0 = act & I_SYM.nb0;
    wire s_bit = act & I_SYM.bit_ok;
    wire s_end_of_data_minimum = act & I_SYM.end_of_data_minimum;
    wire s_end_of_frame_minimum = act & I_SYM.end_of_frame_minimum;
    wire s_brk = act & I_SYM.break_symbol;

    // Break reported once per frame
    wire brk_ev = s_brk & ~brk_r;

    // Invalid bit: edge after too short a run
    wire edge_seen = act & (I_BUS_RECEIVE_INPUT != rxd_d_r);
    wire ibd_ev = edge_seen & (run_r < SHORT_SYMBOL_CYC);

    // Byte assembly and CRC step
    wire byte_done = s_bit & (st_r == RX_DATA) & (bcnt_r == 3'd7);
    wire [7:0] crc_step = {crc_r[6:0], 1'b0}
        ^ ((crc_r[7] ^ I_SYM.bit_val) ? CRC_POLY : 8'h00);
    wire crc_bad = crc_chk_r & (crc_r != CRC_RESIDUE);

    // Frame sequence checks
    wire ifd_gap = (st_r == RX_GAP) & s_sof & ~eodm2_r;
    wire ifd_data = (st_r == RX_DATA) & (s_sof
        | (s_end_of_data_minimum & (bcnt_r != 3'd0 | ycnt_r == 4'd0)));
    wire ifd_idle = (st_r == RX_IDLE) & s_bit;
    wire ifd_second = (st_r == RX_GAP) & eodm2_r & (s_sof | s_nb0 | s_bit);
    wire ifd_len = (st_r == RX_DATA) & s_bit & ~ctl_r[CTL_NFL]
        & (ycnt_r == MAX_FRAME_BYTES);
    wire ifd_ev = ifd_gap | ifd_data | ifd_idle | ifd_second | ifd_len;
    wire eod_ok = (st_r == RX_DATA) & s_end_of_data_minimum & ~ifd_data;
    wire crc_ev = eod_ok & crc_bad;

    // Frame errors raised once, then receiver locks
    wire frame_err = live & ~quiet & (crc_ev | ifd_ev | ibd_ev);

    // Delivery of received bytes, never while asleep
    wire deliver = byte_done & live & ~sleep_r & ~frame_err;
    wire rd_rx = rd_done & sel_rx;

    // Frame tracker next state
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            RX_IDLE: begin
                if (s_sof) begin
                    st_nxt = RX_DATA;
                end
            end
            RX_DATA: begin
                if (eod_ok) begin
                    st_nxt = RX_GAP;
                end
            end
            RX_GAP: begin
                // In-frame response data follows directly
                if (s_nb0 | s_bit) begin
                    st_nxt = RX_DATA;
                end
            end
            RX_LOCK: begin
                st_nxt = RX_LOCK;
            end
            default: begin
                st_nxt = RX_IDLE;
            end
        endcase
        // Lock on error or break; END_OF_FRAME_MINIMUM always re-arms
        if (frame_err | brk_ev) begin
            st_nxt = RX_LOCK;
        end
        if (s_end_of_frame_minimum | kill) begin
            st_nxt = RX_IDLE;
        end
    end

    // Error flag set and clear terms
    logic [7:0] err_set;
    logic [7:0] err_clr;
    logic tmo_hit;
    always_comb begin
        err_set = 8'h00;
        err_set[ERR_TTO] = tmo_hit;
        err_set[ERR_RECEIVE_OVERFLOW_FLAG] = deliver & full_r & ~rd_rx;
        err_set[ERR_TRA] = act & I_TX_ABORT;
        err_set[ERR_BREAK_RECEIVED_FLAG] = s_brk;
        err_set[ERR_CRC_ERROR_FLAG] = frame_err & crc_ev;
        err_set[ERR_IFD] = frame_err & ifd_ev;
        err_set[ERR_IBD] = frame_err & ibd_ev;
        // Read clears only bits that were returned
        err_clr = (rd_done & sel_err) ? rdata_r : 8'h00;
        err_clr[ERR_TTO] = 1'b0;
        err_clr[ERR_TRA] = 1'b0;
        // Break survives reads while it lasts
        err_clr[ERR_BREAK_RECEIVED_FLAG] = err_clr[ERR_BREAK_RECEIVED_FLAG] & ~s_brk;
    end
    // Set wins over clear; disable and freeze force zero
    wire [7:0] err_nxt = kill ? ERR_RST
        : (err_set | (err_r & ~err_clr));

    // Transmit timeout on a stuck active output
    wire [11:0] tmo_lim = ctl_r[CTL_X4] ? TMO_TICKS_4X : TMO_TICKS_1X;
    assign tmo_hit = act & I_TX_OUTPUT_REQ & I_PRESCALE_TICK
        & (tmo_r == tmo_lim - 12'd1);
    assign O_BUS_TRANSMIT_OUTPUT = I_TX_OUTPUT_REQ & act;

    // Sleep bit: only hardware can clear it
    wire slp_force = kill | tmo_hit;
    wire slp_clr = act & (I_SYM.end_of_frame_minimum | I_SYM.eof | I_SYM.break_symbol);
    wire slp_wr = wr_done & sel_prio & wd[PRIO_SLP];
    wire sleep_nxt = slp_force | slp_wr | (sleep_r & ~slp_clr);

    // Cancel queue on break or frame error, never sets abort
    assign O_CANCEL_QUEUE = brk_ev | frame_err;
    assign O_RX_FULL = full_r;
    assign O_END_OF_DATA_MINIMUM_EVENT = s_end_of_data_minimum & ~quiet;

    // Control register; enable needs freeze already clear
    wire [7:0] ctl_w = {wd[CTL_EN] & ~frz & ~wd[CTL_FRZ],
        wd[CTL_FRZ], wd[CTL_NFL], wd[CTL_X4], wd[CTL_SUSP], 3'h0};
    wire [7:0] ctl_nxt = (wr_done & sel_ctl) ? ctl_w : ctl_r;

    // Internal sources and vector encoding
    src_type src;
    src_type grant;
    logic [1:0] enc;
    assign src = '{tx_dma: I_SRC_REQ.tx_dma, rx_dma: I_SRC_REQ.rx_dma,
        err: I_SRC_REQ.err | (|err_r), eom: I_SRC_REQ.eom,
        rxf: I_SRC_REQ.rxf | receive_end_of_block_r, txr: I_SRC_REQ.txr | transmit_end_of_block_r};
    vpw_prio_encoder u_prio (
        .i_req(src),
        .i_suspend(ctl_r[CTL_SUSP]),
        .o_grant(grant),
        .o_enc(enc)
    );
    assign O_GRANT = grant;

    // Read multiplexer, unmapped reads return zero
    wire [7:0] rd_mux = sel_rx ? rxd_r
        : sel_ctl ? ctl_r
        : sel_err ? err_r
        : sel_vec ? {vbase_r, enc, 1'b0}
        : sel_prio ? {prl_r, sleep_r, 2'h0, receive_end_of_block_r, transmit_end_of_block_r}
        : 8'h00;

    // Bus handshake and read capture
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            ack_r <= 1'b0;
            rdata_r <= 8'h00;
        end else begin
            ack_r <= req & ~ack_r;
            rdata_r <= (I_AVS_READ & ~ack_r) ? rd_mux : rdata_r;
        end
    end

    // Software registers
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            ctl_r <= CTL_RST;
            err_r <= ERR_RST;
            vbase_r <= 5'h00;
            prl_r <= PRIO_RST[7:PRL_LSB];
            sleep_r <= PRIO_RST[PRIO_SLP];
        end else begin
            ctl_r <= ctl_nxt;
            err_r <= err_nxt;
            vbase_r <= (wr_done & sel_vec) ? wd[7:3] : vbase_r;
            prl_r <= (wr_done & sel_prio) ? wd[7:PRL_LSB] : prl_r;
            sleep_r <= sleep_nxt;
        end
    end

    // End-of-block pending: hardware sets, software writes zero
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            receive_end_of_block_r <= PRIO_RST[PRIO_RECEIVE_END_OF_BLOCK];
            transmit_end_of_block_r <= PRIO_RST[PRIO_TRANSMIT_END_OF_BLOCK];
        end else begin
            receive_end_of_block_r <= ~frz & (I_RECEIVE_END_OF_BLOCK_SET | (receive_end_of_block_r
                & ~(wr_done & sel_prio & ~wd[PRIO_RECEIVE_END_OF_BLOCK])));
            transmit_end_of_block_r <= ~frz & (I_TRANSMIT_END_OF_BLOCK_SET | (transmit_end_of_block_r
                & ~(wr_done & sel_prio & ~wd[PRIO_TRANSMIT_END_OF_BLOCK])));
        end
    end

    // Receive data register; reading it frees the slot
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rxd_r <= 8'h00;
            full_r <= 1'b0;
        end else begin
            rxd_r <= deliver ? {shf_r[6:0], I_SYM.bit_val} : rxd_r;
            full_r <= ~kill & (deliver | (full_r & ~rd_rx));
        end
    end

    // Frame tracker, byte and CRC accumulation
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            st_r <= RX_IDLE;
            crc_r <= CRC_INIT;
            shf_r <= 8'h00;
            bcnt_r <= 3'h0;
            ycnt_r <= 4'h0;
            crc_chk_r <= 1'b0;
            eodm2_r <= 1'b0;
            brk_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            // CRC restarts at every end of data
            crc_r <= (s_sof | s_nb0 | eod_ok) ? CRC_INIT
                : (s_bit & st_r != RX_IDLE) ? crc_step : crc_r;
            shf_r <= s_bit ? {shf_r[6:0], I_SYM.bit_val} : shf_r;
            bcnt_r <= (s_sof | s_nb0 | s_end_of_data_minimum | s_end_of_frame_minimum) ? 3'h0
                : (s_bit & st_r != RX_IDLE) ? bcnt_r + 3'd1 : bcnt_r;
            ycnt_r <= (s_sof | s_end_of_frame_minimum) ? 4'h0
                : (byte_done & ycnt_r != 4'hF) ? ycnt_r + 4'd1 : ycnt_r;
            // Type 1/2 responses carry no CRC
            crc_chk_r <= (s_sof | s_nb0) ? 1'b1
                : (st_r == RX_GAP & s_bit) ? 1'b0 : crc_chk_r;
            eodm2_r <= (s_sof | s_end_of_frame_minimum) ? 1'b0
                : (eod_ok & ycnt_r != 4'h0 & st_r == RX_DATA
                & crc_chk_r == 1'b0) ? 1'b1
                : (eod_ok & (st_r == RX_DATA)) ? eodm2_r | bcnt_r == 3'h0
                & brk_r == 1'b0 & end_of_data_minimum_seen_r : eodm2_r;
            brk_r <= ~kill & ~s_end_of_frame_minimum & (brk_r | brk_ev);
        end
    end

    // Flags an end-of-data mark already seen in the frame
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            end_of_data_minimum_seen_r <= 1'b0;
        end else begin
            end_of_data_minimum_seen_r <= ~(s_sof | s_end_of_frame_minimum | kill) & (end_of_data_minimum_seen_r | eod_ok);
        end
    end

    // Run length of bus level and transmit timeout
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rxd_d_r <= 1'b0;
            run_r <= SHORT_SYMBOL_CYC;
            tmo_r <= 12'h000;
        end else begin
            rxd_d_r <= I_BUS_RECEIVE_INPUT;
            // Saturates so a long idle never looks short
            run_r <= edge_seen ? 9'd1
                : (run_r < SHORT_SYMBOL_CYC) ? run_r + 9'd1 : run_r;
            tmo_r <= (~act | ~I_TX_OUTPUT_REQ | tmo_hit) ? 12'h000
                : I_PRESCALE_TICK ? tmo_r + 12'd1 : tmo_r;
        end
    end

    // Checks
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RST_N);
    chk_ovf_sets: assert property (deliver && full_r && !rd_rx |=>
        err_r[ERR_RECEIVE_OVERFLOW_FLAG]) else $error("overflow not flagged");
    chk_kill_clears: assert property (kill |=>
        err_r[6:0] == 7'h00) else $error("flags survive disable");
    chk_brk_holds: assert property (s_brk |=>
        err_r[ERR_BREAK_RECEIVED_FLAG] && sleep_r == 1'b0) else $error("break not held");
    chk_quiet_silent: assert property (quiet && live |=>
        $stable(err_r[2:0]) || $rose(kill) || $past(rd_done))
        else $error("error raised while quiet");
    chk_err_locks: assert property (frame_err && !s_end_of_frame_minimum |=>
        st_r == RX_LOCK) else $error("no lock after error");
    chk_len_ifd: assert property (ifd_len && live && !quiet |=>
        err_r[ERR_IFD]) else $error("long frame not flagged");
    chk_tmo_trip: assert property (tmo_hit |=>
        err_r[ERR_TTO] && sleep_r && !O_BUS_TRANSMIT_OUTPUT)
        else $error("timeout without effect");
    chk_sleep_held: assert property (kill |=> sleep_r)
        else $error("sleep not forced");
    chk_sleep_rx: assert property (sleep_r && byte_done |=>
        $stable(rxd_r)) else $error("data taken in sleep");
    chk_wait_one: assert property (req && !ack_r |=>
        !O_AVS_WAITREQUEST) else $error("answer late");
    cov_crc_err: cover property (crc_ev && frame_err);
    cov_break: cover property (brk_ev);
    cov_ovf: cover property (err_set[ERR_RECEIVE_OVERFLOW_FLAG]);
    cov_err_read: cover property (rd_done && sel_err && rdata_r != 8'h00);
endmodule : vpw_err_ctrl
`default_nettype wire

// File: src/vpw_pkg.sv
package vpw_pkg;
    // Clock and symbol timing
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned SHORT_SYMBOL_NS = 35000;
    // Least time, so round up to whole cycles
    localparam logic [8:0] SHORT_SYMBOL_CYC =
        9'((SHORT_SYMBOL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // Transmit timeout in prescaled ticks
    localparam logic [11:0] TMO_TICKS_1X = 12'd1000;
    localparam logic [11:0] TMO_TICKS_4X = 12'd4000;
    // Register indices; byte address is index times four
    localparam int unsigned ADDR_W = 10;
    localparam logic [7:0] IDX_RECEIVE_DATA_REG = 8'hF4;
    localparam logic [7:0] IDX_CTRL = 8'hF5;
    localparam logic [7:0] IDX_ERR = 8'hF7;
    localparam logic [7:0] IDX_VEC = 8'hF8;
    localparam logic [7:0] IDX_PRIO = 8'hF9;
    // Control register fields
    localparam int unsigned CTL_EN = 7;
    localparam int unsigned CTL_FRZ = 6;
    localparam int unsigned CTL_NFL = 5;
    localparam int unsigned CTL_X4 = 4;
    localparam int unsigned CTL_SUSP = 3;
    localparam logic [7:0] CTL_RST = 8'h40;
    // Error register fields
    localparam int unsigned ERR_TTO = 7;
    localparam int unsigned ERR_RECEIVE_OVERFLOW_FLAG = 5;
    localparam int unsigned ERR_TRA = 4;
    localparam int unsigned ERR_BREAK_RECEIVED_FLAG = 3;
    localparam int unsigned ERR_CRC_ERROR_FLAG = 2;
    localparam int unsigned ERR_IFD = 1;
    localparam int unsigned ERR_IBD = 0;
    localparam logic [7:0] ERR_RST = 8'h00;
    // Priority and sleep register fields
    localparam int unsigned PRL_LSB = 5;
    localparam int unsigned PRIO_SLP = 4;
    localparam int unsigned PRIO_RECEIVE_END_OF_BLOCK = 1;
    localparam int unsigned PRIO_TRANSMIT_END_OF_BLOCK = 0;
    localparam logic [7:0] PRIO_RST = 8'h10;
    // Encoded interrupt source codes
    localparam logic [1:0] ENC_ERR = 2'h0;
    localparam logic [1:0] ENC_EOM = 2'h1;
    localparam logic [1:0] ENC_RXF = 2'h2;
    localparam logic [1:0] ENC_TXR = 2'h3;
    // Frame check
    localparam logic [3:0] MAX_FRAME_BYTES = 4'd12;
    localparam logic [7:0] CRC_INIT = 8'hFF;
    localparam logic [7:0] CRC_POLY = 8'h1D;
    localparam logic [7:0] CRC_RESIDUE = 8'hC4;
    // Decoded symbols, one-cycle pulses except brk (level)
    typedef struct packed {
        logic sof;
        logic nb0;
        logic bit_ok;
        logic bit_val;
        logic end_of_data_minimum;
        logic end_of_frame_minimum;
        logic eof;
        logic break_symbol;
    } sym_type;
    // Internal request sources, highest default rank first
    typedef struct packed {
        logic tx_dma;
        logic rx_dma;
        logic err;
        logic eom;
        logic rxf;
        logic txr;
    } src_type;
    typedef enum {RX_IDLE, RX_DATA, RX_GAP, RX_LOCK} rx_state_type;
endpackage : vpw_pkg

// File: src/vpw_prio_encoder.sv
`timescale 1ns/1ns
`default_nettype none
module vpw_prio_encoder (
    // Requests
    input wire vpw_pkg::src_type i_req,
    input wire logic i_suspend,
    // Results
    output vpw_pkg::src_type o_grant,
    output logic [1:0] o_enc
);
    import vpw_pkg::*;
    // Error ranks above DMA only when suspension is on
    wire err_first = i_suspend & i_req.err;
    wire dma_ok = ~err_first;
    wire tx_g = i_req.tx_dma & dma_ok;
    wire rx_g = i_req.rx_dma & dma_ok & ~i_req.tx_dma;
    wire err_g = i_req.err & ~tx_g & ~rx_g;
    wire eom_g = i_req.eom & ~i_req.err & ~tx_g & ~rx_g;
    wire rxf_g = i_req.rxf & ~i_req.eom & ~i_req.err & ~tx_g & ~rx_g;
    wire txr_g = i_req.txr & ~i_req.rxf & ~i_req.eom & ~i_req.err
        & ~tx_g & ~rx_g;
    assign o_grant = '{tx_dma: tx_g, rx_dma: rx_g, err: err_g,
        eom: eom_g, rxf: rxf_g, txr: txr_g};
    // Encoding of highest interrupt source, DMA never encoded
    assign o_enc = i_req.err ? ENC_ERR : i_req.eom ? ENC_EOM :
        i_req.rxf ? ENC_RXF : i_req.txr ? ENC_TXR : ENC_ERR;
endmodule : vpw_prio_encoder
`default_nettype wire

// File: dv/vpw_bus_model.sv
`timescale 1ns/1ns
`default_nettype none
module vpw_bus_model (
    // Clock
    input wire logic i_clk,
    // Toward the block
    output var vpw_pkg::sym_type o_sym,
    output var logic o_level
);
    import vpw_pkg::*;
    // Line held passive: any edge here would be timed as a symbol
    initial begin
        o_sym = '0;
        o_level = 1'b0;
    end
    // One symbol for one cycle; a break stays as a level
    task automatic send(input sym_type s);
        @(posedge i_clk);
        o_sym <= s;
        @(posedge i_clk);
        o_sym <= '{break_symbol: s.break_symbol, default: 1'b0};
    endtask : send
    // Line level raised for a number of cycles, then back to idle
    task automatic pulse(input int unsigned cyc);
        @(posedge i_clk);
        o_level <= 1'b1;
        repeat (cyc) @(posedge i_clk);
        o_level <= 1'b0;
    endtask : pulse
    // Eight data bits, top bit first
    task automatic byte_out(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            send('{bit_ok: 1'b1, bit_val: b[i], default: 1'b0});
        end
    endtask : byte_out
endmodule : vpw_bus_model
`default_nettype wire

// File: dv/vpw_bus_error_irq_sleep_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module vpw_bus_error_irq_sleep_tb_top;
    import vpw_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [9:0] addr = '0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = '0;
    logic [31:0] rdata;
    logic waitreq;
    logic lvl;
    sym_type sym;
    logic tick = 1'b0;
    logic abort = 1'b0;
    logic outreq = 1'b0;
    logic otx;
    logic ocq;
    src_type src = '0;
    src_type grant;
    logic rxfull;
    int bad_count = 0;
    int checks = 0;
    int ncan = 0;
    int neod = 0;
    logic xmit = 1'b0;
    logic [1:0] eob = 2'b00;
    logic end_of_data_minimum_ev;
    // Table: suspend, requests, winner, source code
    logic [14:0] tbl [9] = '{15'h3F80, 15'h7F20, 15'h7780, 15'h1F40,
        15'h0F20, 15'h0711, 15'h030A, 15'h0107, 15'h430A};
    // 10 MHz core clock
    always #50 clk = ~clk;
    // Count queue cancels seen
    always @(posedge clk) if (ocq === 1'b1) ncan <= ncan + 1;
    // Count end-of-data events seen
    always @(posedge clk) if (end_of_data_minimum_ev === 1'b1) neod <= neod + 1;
    vpw_bus_model bm (.i_clk(clk), .o_sym(sym), .o_level(lvl));
    vpw_err_ctrl dut (.I_CORE_CLK(clk), .I_RST_N(rst_n),
        .I_AVS_ADDRESS(addr), .I_AVS_READ(rd), .I_AVS_WRITE(wr),
        .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(4'hF),
        .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(waitreq),
        .I_BUS_RECEIVE_INPUT(lvl), .I_SYM(sym), .I_PRESCALE_TICK(tick),
        .I_TRANSMITTING(xmit), .I_TX_ABORT(abort),
        .I_TX_OUTPUT_REQ(outreq), .O_BUS_TRANSMIT_OUTPUT(otx),
        .O_CANCEL_QUEUE(ocq), .I_SRC_REQ(src), .I_RECEIVE_END_OF_BLOCK_SET(eob[1]),
        .I_TRANSMIT_END_OF_BLOCK_SET(eob[0]), .O_GRANT(grant), .O_RX_FULL(rxfull),
        .O_END_OF_DATA_MINIMUM_EVENT(end_of_data_minimum_ev));
    // Verdict and stop
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test
    // Compare seen against expected
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // One Avalon access; held until waitrequest is seen low
    task automatic acc(input logic w, input logic [7:0] idx,
        input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        @(posedge clk);
        addr <= {idx, 2'b00};
        rd <= !w;
        wr <= w;
        wdata <= {24'h00_0000, d};
        do begin
            @(posedge clk);
            n++;
        end while (waitreq !== 1'b0 && n < 20);
        q = rdata[7:0];
        if (n >= 20) begin
            bad_count++;
            end_of_test;
        end
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : acc
    task automatic wt(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] q;
        acc(1'b1, idx, d, q);
    endtask : wt
    task automatic rc(input logic [7:0] idx, input logic [7:0] e);
        logic [7:0] q;
        acc(1'b0, idx, 8'h00, q);
        chk(q, e);
    endtask : rc
    // Hang guard
    initial begin
        repeat (50000) @(posedge clk);
        bad_count++;
        end_of_test;
    end
    // Main sequence
    initial begin
        logic [14:0] e;
        logic [7:0] q;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rc(IDX_PRIO, PRIO_RST);
        rc(IDX_ERR, ERR_RST);
        wt(IDX_CTRL, 8'h00);
        wt(IDX_CTRL, 8'h80);
        wt(IDX_PRIO, 8'h00);
        rc(IDX_PRIO, 8'h10);
        // Asleep: nothing reaches the data register
        bm.send('{sof: 1'b1, default: 1'b0});
        bm.byte_out(8'hA5);
        bm.send('{end_of_data_minimum: 1'b1, default: 1'b0});
        @(posedge clk);
        chk({7'h00, rxfull}, 8'h00);
        chk(8'(neod), 8'h00);
        bm.send('{end_of_frame_minimum: 1'b1, default: 1'b0});
        rc(IDX_PRIO, 8'h00);
        // Second byte lands on an unread first, then end of data with a bad CRC
        bm.send('{sof: 1'b1, default: 1'b0});
        bm.byte_out(8'h3C);
        @(posedge clk);
        chk({7'h00, rxfull}, 8'h01);
        bm.byte_out(8'h5A);
        rc(IDX_RECEIVE_DATA_REG, 8'h5A);
        bm.send('{end_of_data_minimum: 1'b1, default: 1'b0});
        @(posedge clk);
        chk(8'(ncan), 8'h01);
        chk(8'(neod), 8'h01);
        rc(IDX_ERR, 8'h24);
        rc(IDX_ERR, 8'h00);
        // Locked until end of frame minimum
        bm.byte_out(8'h11);
        @(posedge clk);
        chk({7'h00, rxfull}, 8'h00);
        bm.send('{end_of_frame_minimum: 1'b1, default: 1'b0});
        // Short level on an idle bus, then locked until END_OF_FRAME_MINIMUM
        bm.pulse(10);
        rc(IDX_ERR, 8'h01);
        bm.send('{sof: 1'b1, default: 1'b0});
        bm.byte_out(8'h77);
        @(posedge clk);
        chk({7'h00, rxfull}, 8'h00);
        bm.send('{end_of_frame_minimum: 1'b1, default: 1'b0});
        // Break held across reads
        bm.send('{break_symbol: 1'b1, default: 1'b0});
        @(posedge clk);
        chk(8'(ncan), 8'h03);
        rc(IDX_ERR, 8'h08);
        rc(IDX_ERR, 8'h08);
        bm.send('0);
        rc(IDX_ERR, 8'h08);
        rc(IDX_ERR, 8'h00);
        // Aborted opcode, cleared only by disable or freeze
        @(posedge clk);
        abort <= 1'b1;
        @(posedge clk);
        abort <= 1'b0;
        rc(IDX_ERR, 8'h10);
        wt(IDX_CTRL, 8'h00);
        rc(IDX_ERR, 8'h00);
        rc(IDX_PRIO, 8'h10);
        wt(IDX_PRIO, 8'hE0);
        rc(IDX_PRIO, 8'hF0);
        // Internal ranking, both suspend settings
        wt(IDX_VEC, 8'hFF);
        foreach (tbl[i]) begin
            e = tbl[i];
            wt(IDX_CTRL, {4'h8, e[14], 3'h0});
            src <= e[13:8];
            repeat (2) @(posedge clk);
            chk({2'b00, grant}, {2'b00, e[7:2]});
            if (e[7:6] == 2'b00) begin
                acc(1'b0, IDX_VEC, 8'h00, q);
                chk(q, {5'h1F, e[1:0], 1'b0});
            end
        end
        src <= '0;
        // End-of-block pending set, then wiped by freeze
        @(posedge clk);
        eob <= 2'b11;
        @(posedge clk);
        eob <= 2'b00;
        rc(IDX_PRIO, 8'hF3);
        wt(IDX_CTRL, 8'h40);
        rc(IDX_PRIO, 8'hF0);
        wt(IDX_CTRL, 8'h00);
        // Output held active, plain then 4x: trips at the last tick
        for (int m = 0; m < 2; m++) begin
            wt(IDX_CTRL, (m != 0) ? 8'h90 : 8'h80);
            outreq <= 1'b1;
            repeat ((m != 0) ? 3999 : 999) begin
                @(posedge clk);
                tick <= 1'b1;
                @(posedge clk);
                tick <= 1'b0;
            end
            @(posedge clk);
            chk({7'h00, otx}, 8'h01);
            tick <= 1'b1;
            @(posedge clk);
            tick <= 1'b0;
            repeat (2) @(posedge clk);
            chk({7'h00, otx}, 8'h00);
            outreq <= 1'b0;
            rc(IDX_ERR, 8'h80);
            wt(IDX_CTRL, 8'h00);
            rc(IDX_ERR, 8'h00);
        end
        // Asleep but transmitting: errors kept, data dropped
        wt(IDX_CTRL, 8'h80);
        xmit <= 1'b1;
        bm.send('{sof: 1'b1, default: 1'b0});
        bm.byte_out(8'h3C);
        bm.byte_out(8'h5A);
        bm.send('{end_of_data_minimum: 1'b1, default: 1'b0});
        @(posedge clk);
        chk({7'h00, rxfull}, 8'h00);
        rc(IDX_ERR, 8'h04);
        xmit <= 1'b0;
        end_of_test;
    end
endmodule : vpw_bus_error_irq_sleep_tb_top
`default_nettype wire
